//--- verilog/fsf_pkg.sv
// constants for the fault status flag register bank
package fsf_pkg;

	// ==========================================
	// bus geometry
	localparam int unsigned ADDR_W = 10;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned NUM_IN = 4;
	localparam int unsigned FILT_W = 4;

	// ==========================================
	// register indices, byte address is index times four
	localparam logic [7:0] IDX_MODE = 8'h20;
	localparam logic [7:0] IDX_STATUS = 8'h25;
	localparam logic [7:0] IDX_FILT = 8'h28;
	localparam logic [7:0] IDX_CTRL = 8'h29;
	localparam logic [9:0] ADDR_MODE = {IDX_MODE, 2'h0};
	localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
	localparam logic [9:0] ADDR_FILT = {IDX_FILT, 2'h0};
	localparam logic [9:0] ADDR_CTRL = {IDX_CTRL, 2'h0};

	// ==========================================
	// field positions
	localparam int unsigned ST_ANY = 7;
	localparam int unsigned ST_WPON = 6;
	localparam int unsigned ST_LEVEL = 5;
	localparam int unsigned ST_RSVD = 4;
	localparam int unsigned MODE_FCTL = 0;
	localparam int unsigned MODE_WPOFF = 2;
	localparam int unsigned CTRL_FEN_LO = 4;

	// ==========================================
	// reset values
	localparam logic RST_WP = 1'b0;
	localparam logic RST_FCTL = 1'b0;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [3:0] RST_FILT = 4'h0;
	localparam logic [3:0] RST_FLAGS = 4'h0;

	// ==========================================
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : fsf_pkg

//--- verilog/fsf_fault_in.sv
// one fault input: three-stage synchroniser and optional glitch filter
module fsf_fault_in #(
	parameter int unsigned FILT_W = 4
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic pin,
	input wire logic filt_en,
	input wire logic [FILT_W-1:0] filt_val,
	output logic level
);
	if (FILT_W < 1 || FILT_W > 16) begin : g_bad_filt_w
		$error("FILT_W out of range");
	end

	logic s1_q, s2_q, s3_q, lvl_q, filt_q;
	logic [FILT_W-1:0] cnt_q;

	// ==========================================
	// synchroniser, change taken when stages two and three agree
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			lvl_q <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				lvl_q <= s3_q;
			end
		end
	end

	// ==========================================
	// filter: new level must stand filt_val cycles
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
			filt_q <= 1'b0;
		end else if (lvl_q == filt_q) begin
			cnt_q <= '0;
		end else if (cnt_q + FILT_W'(1) >= filt_val) begin
			cnt_q <= '0;
			filt_q <= lvl_q;
		end else begin
			cnt_q <= cnt_q + FILT_W'(1);
		end
	end

	assign level = (filt_en && filt_val != '0) ? filt_q : lvl_q;

endmodule : fsf_fault_in

//--- verilog/fsf_status_regs.sv
// fault status flag register bank with AXI4-Lite slave
module fsf_status_regs (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [fsf_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [fsf_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [fsf_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [fsf_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic [3:0] fault_pin,
	output logic [3:0] per_input_fault_flag,
	output logic any_fault_flag,
	output logic fault_input_level,
	output logic write_protect_on
);
	localparam int unsigned N = fsf_pkg::NUM_IN;

	// ==========================================
	// bus slave
	logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
	logic [fsf_pkg::ADDR_W-1:0] awaddr_q;
	logic [7:0] wdata_q;
	logic wstrb0_q;
	logic [1:0] bresp_q, rresp_q;
	logic [fsf_pkg::DATA_W-1:0] rdata_q;
	logic do_wr, ar_hs, wr_mode, wr_status, wr_ctrl, wr_filt, rd_status, wa_ok, ra_ok;
	logic [7:0] rd_mux;

	assign s_axi_awready = !aw_hold_q;
	assign s_axi_wready = !w_hold_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	assign do_wr = aw_hold_q && w_hold_q && !bvalid_q;
	assign ar_hs = s_axi_arvalid && !rvalid_q;
	assign wa_ok = awaddr_q == fsf_pkg::ADDR_MODE || awaddr_q == fsf_pkg::ADDR_STATUS
		|| awaddr_q == fsf_pkg::ADDR_FILT || awaddr_q == fsf_pkg::ADDR_CTRL;
	assign ra_ok = s_axi_araddr == fsf_pkg::ADDR_MODE || s_axi_araddr == fsf_pkg::ADDR_STATUS
		|| s_axi_araddr == fsf_pkg::ADDR_FILT || s_axi_araddr == fsf_pkg::ADDR_CTRL;
	assign wr_status = do_wr && wstrb0_q && awaddr_q == fsf_pkg::ADDR_STATUS;
	assign rd_status = ar_hs && s_axi_araddr == fsf_pkg::ADDR_STATUS;
	assign wr_mode = do_wr && wstrb0_q && awaddr_q == fsf_pkg::ADDR_MODE;
	assign wr_ctrl = do_wr && wstrb0_q && awaddr_q == fsf_pkg::ADDR_CTRL;
	assign wr_filt = do_wr && wstrb0_q && awaddr_q == fsf_pkg::ADDR_FILT;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 8'h00;
			wstrb0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= fsf_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_hold_q) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_hold_q) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata[7:0];
				wstrb0_q <= s_axi_wstrb[0];
			end
			if (do_wr) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wa_ok ? fsf_pkg::RESP_OKAY : fsf_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= fsf_pkg::RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_q <= 1'b1;
			rdata_q <= {24'h000000, rd_mux};
			rresp_q <= ra_ok ? fsf_pkg::RESP_OKAY : fsf_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ==========================================
	// control registers
	logic wp_q, wp_arm_q, fctl_q;
	logic [7:0] ctrl_q;
	logic [3:0] filt_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wp_q <= fsf_pkg::RST_WP;
			wp_arm_q <= 1'b0;
		end else begin
			if (wr_status && wdata_q[fsf_pkg::ST_WPON]) begin
				wp_q <= 1'b1;
				wp_arm_q <= 1'b0;
			end else if (wr_mode && wdata_q[fsf_pkg::MODE_WPOFF] && wp_arm_q) begin
				wp_q <= 1'b0;
				wp_arm_q <= 1'b0;
			end else if (rd_status && wp_q) begin
				wp_arm_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fctl_q <= fsf_pkg::RST_FCTL;
			ctrl_q <= fsf_pkg::RST_CTRL;
			filt_q <= fsf_pkg::RST_FILT;
		end else if (!wp_q) begin
			if (wr_mode) begin
				fctl_q <= wdata_q[fsf_pkg::MODE_FCTL];
			end
			if (wr_ctrl) begin
				ctrl_q <= wdata_q;
			end
			if (wr_filt) begin
				filt_q <= wdata_q[3:0];
			end
		end
	end

	// ==========================================
	// fault inputs
	logic [N-1:0] lvl, cond;
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_in
			fsf_fault_in #(.FILT_W(fsf_pkg::FILT_W)) u_in (
				.clk(clk),
				.arst_n(arst_n),
				.pin(fault_pin[gi]),
				.filt_en(ctrl_q[fsf_pkg::CTRL_FEN_LO + gi]),
				.filt_val(filt_q),
				.level(lvl[gi])
			);
		end
	endgenerate

	assign cond = {N{fctl_q}} & ctrl_q[N-1:0] & lvl;

	// ==========================================
	// sticky flags and clearing sequence
	logic [N-1:0] flag_q, arm_q, clr;
	logic agg_arm_q, clr_all, level_q;

	assign clr = {N{wr_status}} & ~wdata_q[N-1:0] & arm_q & ~cond;
	assign clr_all = wr_status && !wdata_q[fsf_pkg::ST_ANY] && agg_arm_q && cond == '0;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_q <= fsf_pkg::RST_FLAGS;
			arm_q <= '0;
			agg_arm_q <= 1'b0;
			level_q <= 1'b0;
		end else begin
			flag_q <= cond | (flag_q & ~clr & ~{N{clr_all}});
			arm_q <= ((wr_status ? '0 : arm_q) | (rd_status ? flag_q : '0)) & ~cond;
			agg_arm_q <= ((wr_status ? 1'b0 : agg_arm_q) | (rd_status && flag_q != '0)) && cond == '0;
			level_q <= |cond;
		end
	end

	// ==========================================
	// read mux
	always_comb begin
		rd_mux = 8'h00;
		case (s_axi_araddr)
			fsf_pkg::ADDR_STATUS: begin
				rd_mux[fsf_pkg::ST_ANY] = |flag_q;
				rd_mux[fsf_pkg::ST_WPON] = wp_q;
				rd_mux[fsf_pkg::ST_LEVEL] = level_q;
				rd_mux[fsf_pkg::ST_RSVD] = 1'b0;
				rd_mux[N-1:0] = flag_q;
			end
			fsf_pkg::ADDR_MODE: begin
				rd_mux[fsf_pkg::MODE_FCTL] = fctl_q;
				rd_mux[fsf_pkg::MODE_WPOFF] = !wp_q;
			end
			fsf_pkg::ADDR_CTRL: rd_mux = ctrl_q;
			fsf_pkg::ADDR_FILT: rd_mux[3:0] = filt_q;
			default: rd_mux = 8'h00;
		endcase
	end

	assign per_input_fault_flag = flag_q;
	assign any_fault_flag = |flag_q;
	assign fault_input_level = level_q;
	assign write_protect_on = wp_q;

	// ==========================================
	// assertions
	property p_wp_block;
		@(posedge clk) disable iff (!arst_n) (wr_ctrl && wp_q) |=> ctrl_q == $past(ctrl_q);
	endproperty
	a_wp_block: assert property (p_wp_block) else $error("protected write took effect");

	property p_level;
		@(posedge clk) disable iff (!arst_n) ##1 fault_input_level == $past(fctl_q && (ctrl_q[N-1:0] & lvl) != '0);
	endproperty
	a_level: assert property (p_level) else $error("level bit wrong");

	property p_rsvd;
		@(posedge clk) disable iff (!arst_n) rd_status |=> s_axi_rdata[fsf_pkg::ST_RSVD] == 1'b0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

	property p_set;
		@(posedge clk) disable iff (!arst_n) cond != '0 |=> (flag_q & $past(cond)) == $past(cond);
	endproperty
	a_set: assert property (p_set) else $error("fault flag not set");

	property p_clear_cause;
		@(posedge clk) disable iff (!arst_n) (flag_q != '0) ##1 ((~flag_q & $past(flag_q)) != '0) |-> $past(wr_status);
	endproperty
	a_clear_cause: assert property (p_clear_cause) else $error("flag cleared without write");

	property p_write_one;
		@(posedge clk) disable iff (!arst_n)
			(wr_status && wdata_q[3:0] == 4'hF && wdata_q[fsf_pkg::ST_ANY]) |=> flag_q == ($past(flag_q) | $past(cond));
	endproperty
	a_write_one: assert property (p_write_one) else $error("write of one changed flags");

	property p_agg_clear;
		@(posedge clk) disable iff (!arst_n) clr_all |=> flag_q == '0;
	endproperty
	a_agg_clear: assert property (p_agg_clear) else $error("aggregate clear left flags");

	property p_rearm;
		@(posedge clk) disable iff (!arst_n) cond != '0 |=> (arm_q & $past(cond)) == '0;
	endproperty
	a_rearm: assert property (p_rearm) else $error("sequence not restarted");

	property p_any;
		@(posedge clk) disable iff (!arst_n) rd_status |=> s_axi_rdata[fsf_pkg::ST_ANY] == |$past(flag_q);
	endproperty
	a_any: assert property (p_any) else $error("aggregate bit wrong");

	property p_wp_hold;
		@(posedge clk) disable iff (!arst_n) (wr_mode && !wp_arm_q && wp_q) |=> wp_q;
	endproperty
	a_wp_hold: assert property (p_wp_hold) else $error("protection dropped without read");

	property p_decode;
		@(posedge clk) disable iff (!arst_n) rd_status |=> s_axi_rvalid && s_axi_rresp == fsf_pkg::RESP_OKAY;
	endproperty
	a_decode: assert property (p_decode) else $error("status not decoded");

endmodule : fsf_status_regs

//--- dv/fsf_fault_src.sv
// model of the external fault sources feeding the fault pins
module fsf_fault_src (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [3:0] fault_req,
	output logic [3:0] fault_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_pin <= 4'h0;
		end else begin
			fault_pin <= fault_req;
		end
	end
endmodule : fsf_fault_src

//--- dv/tb_fault_status_flags.sv
// self-checking bench for the fault status flag bank
module tb_fault_status_flags;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [9:0] ST = fsf_pkg::ADDR_STATUS;
	localparam logic [9:0] MD = fsf_pkg::ADDR_MODE;
	localparam logic [9:0] CT = fsf_pkg::ADDR_CTRL;
	logic clk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, any_flag, level, wp_on;
	logic [9:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, fault_req, fault_pin, flags;
	logic [1:0] bresp, rresp, last_bresp;
	int failures = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [9:0] row_addr [5] = '{MD, ST, fsf_pkg::ADDR_FILT, CT, 10'h3F0};
	logic [33:0] row_exp [5] = '{34'h4, 34'h0, 34'h0, 34'h0, 34'h200000000};

	fsf_status_regs fsf_status_regs_i (.clk(clk), .arst_n(arst_n), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.fault_pin(fault_pin), .per_input_fault_flag(flags), .any_fault_flag(any_flag),
		.fault_input_level(level), .write_protect_on(wp_on));
	fsf_fault_src fsf_fault_src_i (.clk(clk), .arst_n(arst_n), .fault_req(fault_req), .fault_pin(fault_pin));

	// ==========================================
	// bench tasks
	task automatic give_verdict();
		if (failures == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= {24'h0, d};
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awready && !aw_done) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !w_done) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
			if (bvalid) begin
				last_bresp = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : wr

	task automatic rd(input logic [9:0] a, output logic [33:0] v);
		logic ar_done;
		ar_done = 1'b0;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arready && !ar_done) begin
				ar_done = 1'b1;
				arvalid <= 1'b0;
			end
			if (rvalid) begin
				v = {rresp, rdata};
				rready <= 1'b0;
				break;
			end
		end
	endtask : rd

	task automatic rchk(input logic [9:0] a, input logic [7:0] e);
		logic [33:0] v;
		rd(a, v);
		chk(v, {fsf_pkg::RESP_OKAY, 24'h0, e});
	endtask : rchk

	// fault set up or released, then given time through the synchroniser
	task automatic fault(input logic [3:0] f);
		fault_req <= f;
		repeat (10) @(posedge clk);
	endtask : fault

	task automatic do_reset();
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
	endtask : do_reset

	// ==========================================
	// clock and timeout
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			give_verdict();
		end
	end

	// ==========================================
	// main sequence
	initial begin
		logic [33:0] v;
		{arst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		awaddr = 10'h0;
		araddr = 10'h0;
		wdata = 32'h0;
		wstrb = 4'hF;
		fault_req = 4'h0;
		do_reset();
		foreach (row_addr[i]) begin
			rd(row_addr[i], v);
			chk(v, row_exp[i]);
		end
		fault(4'h1);
		rchk(ST, 8'h00);
		wr(CT, 8'h0F);
		wr(MD, 8'h05);
		fault(4'h1);
		rchk(ST, 8'hA1);
		chk({29'h0, any_flag, flags}, 34'h11);
		wr(ST, 8'h0F);
		rchk(ST, 8'hA1);
		wr(ST, 8'h80);
		rchk(ST, 8'hA1);
		fault(4'h0);
		rchk(ST, 8'h81);
		wr(ST, 8'h80);
		rchk(ST, 8'h00);
		fault(4'h1);
		fault(4'h0);
		rchk(ST, 8'h81);
		wr(ST, 8'h9F);
		rchk(ST, 8'h81);
		fault(4'h1);
		fault(4'h0);
		wr(ST, 8'h80);
		rchk(ST, 8'h81);
		fault(4'h6);
		fault(4'h0);
		rchk(ST, 8'h87);
		wr(ST, 8'h0F);
		rchk(ST, 8'h00);
		wr(ST, 8'h40);
		chk({33'h0, wp_on}, 34'h1);
		wr(CT, 8'hF0);
		rchk(CT, 8'h0F);
		wr(MD, 8'h04);
		rchk(MD, 8'h01);
		rchk(ST, 8'h40);
		wr(MD, 8'h05);
		rchk(MD, 8'h05);
		wr(CT, 8'hFF);
		rchk(CT, 8'hFF);
		wstrb <= 4'hE;
		wr(CT, 8'h00);
		wstrb <= 4'hF;
		rchk(CT, 8'hFF);
		wr(10'h3FC, 8'hFF);
		chk({32'h0, last_bresp}, {32'h0, fsf_pkg::RESP_SLVERR});
		wr(fsf_pkg::ADDR_FILT, 8'h08);
		rchk(fsf_pkg::ADDR_FILT, 8'h08);
		fault_req <= 4'h2;
		repeat (3) @(posedge clk);
		fault(4'h0);
		rchk(ST, 8'h00);
		fault(4'h2);
		fault(4'h2);
		rchk(ST, 8'hA2);
		chk({33'h0, level}, 34'h1);
		fault(4'h0);
		fault(4'h0);
		chk({33'h0, level}, 34'h0);
		fault(4'h8);
		fault(4'h8);
		rchk(ST, 8'hAA);
		do_reset();
		chk({29'h0, any_flag, flags}, 34'h0);
		rchk(ST, 8'h00);
		give_verdict();
	end
endmodule : tb_fault_status_flags
